// [src/isq_defs.svh]
`ifndef ISQ_DEFS_SVH
`define ISQ_DEFS_SVH

// vector pairs: high address byte at the lower location
`define ISQ_VEC_RESET     14'h1ffe
`define ISQ_VEC_SOFT      14'h1ffc
`define ISQ_VEC_EXT1      14'h1ffa
`define ISQ_VEC_TIMER     14'h1ff8
`define ISQ_VEC_SERIAL    14'h1ff6

// stack pointer: fixed upper bits, six moving bits
`define ISQ_SP_FIXED      8'h03
`define ISQ_SP_RST        6'h3f
`define ISQ_SP_FLOOR      14'h00c1

// byte counts of the stacking sequences
`define ISQ_IRQ_PUSH_N    3'h5
`define ISQ_CALL_PUSH_N   3'h2
`define ISQ_RTI_PULL_N    3'h5
`define ISQ_RTS_PULL_N    3'h2
`define ISQ_VEC_READ_N    3'h2

// read tags, also the pull order of a full frame
`define ISQ_TAG_FLAGS     3'h0
`define ISQ_TAG_ACC       3'h1
`define ISQ_TAG_IDX       3'h2
`define ISQ_TAG_PCH       3'h3
`define ISQ_TAG_PCL       3'h4

// flag register layout
`define ISQ_FLAG_C        0
`define ISQ_FLAG_Z        1
`define ISQ_FLAG_N        2
`define ISQ_FLAG_I        3
`define ISQ_FLAG_H        4
`define ISQ_CC_PAD        3'h7

// misc control register layout and reset value
`define ISQ_MISC_REQ_BIT  7
`define ISQ_MISC_MASK_BIT 6
`define ISQ_MISC_RST_MASK 1'h1

`endif

// [src/isq_edge_latch.sv]
`timescale 1ns/10ps
`include "isq_defs.svh"
module isq_edge_latch import isq_pkg::*; (
   input  wire logic   mclk,
   input  wire logic   rstAny,
   isq_link_if.edge_unit lnk
);

   typedef struct packed {
      logic [1:0] prevPin;
      logic [1:0] req;
      logic       mask;
   } isq_edge_state_t;

   isq_edge_state_t r;
   isq_edge_state_t n;
   logic [1:0]      fall;
   logic            swClear;

   genvar i;
   generate
      for (i = 0; i < 2; i++) begin : g_pin
         assign fall[i] = r.prevPin[i] & ~lnk.extPinN[i];
      end
   endgenerate

   // a written one leaves the request alone, so software cannot raise it
   assign swClear = lnk.miscWr & ~lnk.miscWrData[`ISQ_MISC_REQ_BIT];

   always_comb begin
      n         = r;
      n.prevPin = lnk.extPinN;
      // set wins over clear in the same cycle
      n.req[0]  = fall[0] | (r.req[0] & ~lnk.clrPrimary);
      n.req[1]  = fall[1] | (r.req[1] & ~swClear);
      if (lnk.miscWr) begin
         n.mask = lnk.miscWrData[`ISQ_MISC_MASK_BIT];
      end
   end

   always_ff @(posedge mclk or posedge rstAny) begin
      if (rstAny) begin
         r.prevPin <= 2'h3;
         r.req     <= 2'h0;
         r.mask    <= `ISQ_MISC_RST_MASK;
      end else begin
         r <= n;
      end
   end

   assign lnk.pendPrimary   = r.req[0];
   assign lnk.pendSecondary = r.req[1];
   assign lnk.maskSecondary = r.mask;
   assign lnk.miscRdData    = {r.req[1], r.mask, 6'h00};
   // test branches look at the raw pin, never at the detector
   assign lnk.pinLevel      = lnk.extPinN;

endmodule : isq_edge_latch

// [src/isq_flag_unit.sv]
`timescale 1ns/10ps
`include "isq_defs.svh"
module isq_flag_unit import isq_pkg::*; (
   input  wire logic   mclk,
   input  wire logic   rstAny,
   isq_link_if.flag_unit lnk
);

   typedef struct packed {
      logic h;
      logic n;
      logic z;
      logic c;
   } isq_flags_t;

   isq_flags_t r;
   isq_flags_t n;
   logic [8:0] sum;
   logic [4:0] lowSum;
   logic       cin;

   always_comb begin
      n      = r;
      cin    = (lnk.flagOp == ISQ_FOP_ADC) ? r.c : 1'b0;
      lowSum = {1'b0, lnk.opA[3:0]} + {1'b0, lnk.opB[3:0]} + {4'h0, cin};
      sum    = {1'b0, lnk.opA} + {1'b0, lnk.opB} + {8'h00, cin};
      if (lnk.restore) begin
         n.h = lnk.restoreVal[`ISQ_FLAG_H];
         n.n = lnk.restoreVal[`ISQ_FLAG_N];
         n.z = lnk.restoreVal[`ISQ_FLAG_Z];
         n.c = lnk.restoreVal[`ISQ_FLAG_C];
      end else begin
         unique case (lnk.flagOp)
            ISQ_FOP_NONE: begin
            end
            ISQ_FOP_ADD, ISQ_FOP_ADC: begin
               n.h = lowSum[4];
               n.c = sum[8];
               n.n = sum[7];
               n.z = (sum[7:0] == 8'h00);
            end
            ISQ_FOP_SUB: begin
               // borrow out of the top bit
               sum = {1'b0, lnk.opA} - {1'b0, lnk.opB};
               n.c = sum[8];
               n.n = sum[7];
               n.z = (sum[7:0] == 8'h00);
            end
            ISQ_FOP_LOGIC: begin
               n.n = lnk.result[7];
               n.z = (lnk.result == 8'h00);
            end
            ISQ_FOP_BITTEST: begin
               n.c = lnk.bitIn;
            end
            ISQ_FOP_ROTATE: begin
               n.c = lnk.bitIn;
               n.n = lnk.result[7];
               n.z = (lnk.result == 8'h00);
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge mclk or posedge rstAny) begin
      if (rstAny) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign lnk.hnzc = {r.h, r.n, r.z, r.c};

endmodule : isq_flag_unit

// [src/isq_link_if.sv]
`timescale 1ns/10ps
interface isq_link_if import isq_pkg::*;;
   // edge and request side
   logic [1:0] extPinN;
   logic       clrPrimary;
   logic       miscWr;
   logic [7:0] miscWrData;
   logic       pendPrimary;
   logic       pendSecondary;
   logic       maskSecondary;
   logic [7:0] miscRdData;
   logic [1:0] pinLevel;
   // flag side
   isq_fop_t   flagOp;
   logic [7:0] opA;
   logic [7:0] opB;
   logic [7:0] result;
   logic       bitIn;
   logic       restore;
   logic [7:0] restoreVal;
   logic [3:0] hnzc;

   modport edge_unit (
      input  extPinN, clrPrimary, miscWr, miscWrData,
      output pendPrimary, pendSecondary, maskSecondary, miscRdData,
             pinLevel
   );
   modport flag_unit (
      input  flagOp, opA, opB, result, bitIn, restore, restoreVal,
      output hnzc
   );
   modport seq (
      output extPinN, clrPrimary, miscWr, miscWrData, flagOp, opA, opB,
             result, bitIn, restore, restoreVal,
      input  pendPrimary, pendSecondary, maskSecondary, miscRdData,
             pinLevel, hnzc
   );
endinterface : isq_link_if

// [src/isq_pkg.sv]
package isq_pkg;

   typedef enum logic [1:0] {
      ISQ_ST_RUN,
      ISQ_ST_PUSH,
      ISQ_ST_FETCH,
      ISQ_ST_DRAIN
   } isq_state_t;

   typedef enum logic [1:0] {
      ISQ_KIND_IRQ,
      ISQ_KIND_CALL,
      ISQ_KIND_RTI,
      ISQ_KIND_RTS
   } isq_kind_t;

   typedef enum logic [2:0] {
      ISQ_CMD_NONE,
      ISQ_CMD_CALL,
      ISQ_CMD_SUB_RETURN,
      ISQ_CMD_SOFT_TRAP,
      ISQ_CMD_TRAP_RETURN,
      ISQ_CMD_SP_PRESET,
      ISQ_CMD_UNMASK,
      ISQ_CMD_MASK
   } isq_cmd_t;

   typedef enum logic [2:0] {
      ISQ_FOP_NONE,
      ISQ_FOP_ADD,
      ISQ_FOP_ADC,
      ISQ_FOP_SUB,
      ISQ_FOP_LOGIC,
      ISQ_FOP_BITTEST,
      ISQ_FOP_ROTATE
   } isq_fop_t;

endpackage : isq_pkg

// [src/isq_top.sv]
// Overview of operation
// - six sources; second pin shares first timer vector, serial shares timer two
// - priority reset, soft trap, first pin, timer pair, serial pair; fixed vectors
// - taking an interrupt stacks state, sets the mask, then fetches the vector
// - push order: pc low, pc high, index, accumulator, flags; decrement each
// - a subroutine call stacks only the two program counter bytes
// - trap return pulls the saved state and resumes at the saved pc
// - stack pointer presets to 00ff; push decrements, pull increments, top fixed
// - stack room for 31 call levels or 12 interrupt levels
// - program counter is 14 bits and holds the next instruction address
// - half carry is the carry from bit 3 into bit 4 on additions
// - negative copies result bit 7; zero flags an all-zero result
// - carry holds carry or borrow; bit test and rotate also set it
// - mask holds all but soft trap; service waits one instruction after unmask
// - both external pins latch a request on a falling edge
// - first pin request clears itself when its vector is taken
// - standby pin low holds all internal state in reset
// - index register plus offset forms an address; also a data holder
// - misc bit 6 masks the second pin; reset clears bit 7, sets bit 6
// - the second pin request bit reads back; a written one does nothing
// - pin test branches read the raw pins, not the edge latches
`timescale 1ns/10ps
`include "isq_defs.svh"
module isq_top import isq_pkg::*; (
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   input  wire logic        standbyPinN,
   input  wire logic        extIrqPrimaryN,
   input  wire logic        extIrqSecondaryN,
   input  wire logic        timerEvent,
   input  wire logic        secondTimerEvent,
   input  wire logic        serialEvent,
   input  wire logic        instrDone,
   input  wire logic        cmdValid,
   input  wire isq_cmd_t    cmd,
   input  wire logic [13:0] callTarget,
   input  wire logic        pcLoad,
   input  wire logic [13:0] pcValue,
   input  wire logic        accWr,
   input  wire logic [7:0]  accWrData,
   input  wire logic        idxWr,
   input  wire logic [7:0]  idxWrData,
   input  wire logic [13:0] idxOffset,
   input  wire isq_fop_t    flagOp,
   input  wire logic [7:0]  aluA,
   input  wire logic [7:0]  aluB,
   input  wire logic [7:0]  aluResult,
   input  wire logic        aluBit,
   input  wire logic        miscWr,
   input  wire logic [7:0]  miscWrData,
   input  wire logic [7:0]  memRdData,
   output logic             busy,
   output logic [13:0]      memAddr,
   output logic [7:0]       memWrData,
   output logic             memWe,
   output logic             memRe,
   output logic [13:0]      pc,
   output logic [13:0]      sp,
   output logic [7:0]       acc,
   output logic [7:0]       idx,
   output logic [7:0]       flagRegister,
   output logic [13:0]      effAddr,
   output logic [7:0]       miscRdData,
   output logic             pinPrimaryLevel,
   output logic             pinSecondaryLevel,
   output logic             stackAtLimit
);

   ////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      isq_state_t  st;
      isq_kind_t   kind;
      logic [2:0]  step;
      logic [2:0]  count;
      logic [5:0]  spLow;
      logic [13:0] pc;
      logic [13:0] target;
      logic [13:0] vec;
      logic [7:0]  acc;
      logic [7:0]  idx;
      logic        iMask;
      logic        defer;
      logic        clrPrimary;
      logic        rdV1;
      logic [2:0]  rdTag1;
      logic        rdV2;
      logic [2:0]  rdTag2;
      logic [13:0] memAddr;
      logic [7:0]  memWrData;
      logic        memWe;
      logic        memRe;
   } isq_seq_state_t;

   isq_seq_state_t r;
   isq_seq_state_t n;
   logic           rstAny;
   logic           flagRestore;
   logic [13:0]    spAddr;
   logic [13:0]    spAddrUp;
   logic           pendTimerPair;
   logic           pendSerialPair;
   logic           anyPend;
   logic [13:0]    pickVec;

   isq_link_if lnk ();

   // standby acts exactly like the reset pin; oscillator stop is off-chip
   assign rstAny = sys_rst | ~standbyPinN;

   ////////////////////////////////////////////////////////////////////////
   isq_edge_latch u_edge (
      .mclk   (mclk),
      .rstAny (rstAny),
      .lnk    (lnk.edge_unit)
   );

   isq_flag_unit u_flag (
      .mclk   (mclk),
      .rstAny (rstAny),
      .lnk    (lnk.flag_unit)
   );

   assign lnk.extPinN    = {extIrqSecondaryN, extIrqPrimaryN};
   assign lnk.clrPrimary = r.clrPrimary;
   assign lnk.miscWr     = miscWr;
   assign lnk.miscWrData = miscWrData;
   // the core is stalled during sequences, so ALU flag ops are ignored
   assign lnk.flagOp     = (r.st == ISQ_ST_RUN) ? flagOp : ISQ_FOP_NONE;
   assign lnk.opA        = aluA;
   assign lnk.opB        = aluB;
   assign lnk.result     = aluResult;
   assign lnk.bitIn      = aluBit;
   assign lnk.restore    = flagRestore;
   assign lnk.restoreVal = memRdData;

   ////////////////////////////////////////////////////////////////////////
   assign spAddr   = {`ISQ_SP_FIXED, r.spLow};
   assign spAddrUp = {`ISQ_SP_FIXED, r.spLow + 6'h01};

   // shared vectors: the handler polls the source flags to tell them apart
   assign pendTimerPair  = timerEvent
                         | (lnk.pendSecondary & ~lnk.maskSecondary);
   assign pendSerialPair = serialEvent | secondTimerEvent;
   assign anyPend = lnk.pendPrimary | pendTimerPair | pendSerialPair;

   always_comb begin
      if (lnk.pendPrimary) begin
         pickVec = `ISQ_VEC_EXT1;
      end else if (pendTimerPair) begin
         pickVec = `ISQ_VEC_TIMER;
      end else begin
         pickVec = `ISQ_VEC_SERIAL;
      end
   end

   function automatic logic [7:0] push_byte(input isq_seq_state_t s,
                                            input logic [7:0] cc);
      unique case (s.step)
         3'h0:    push_byte = s.pc[7:0];
         3'h1:    push_byte = {2'h0, s.pc[13:8]};
         3'h2:    push_byte = s.idx;
         3'h3:    push_byte = s.acc;
         default: push_byte = cc;
      endcase
   endfunction : push_byte

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      n            = r;
      flagRestore  = 1'b0;
      n.memWe      = 1'b0;
      n.memRe      = 1'b0;
      n.clrPrimary = 1'b0;
      n.rdV1       = 1'b0;
      n.rdV2       = r.rdV1;
      n.rdTag2     = r.rdTag1;

      // read data arrives the cycle after memRe is seen
      if (r.rdV2) begin
         unique case (r.rdTag2)
            `ISQ_TAG_FLAGS: begin
               n.iMask     = memRdData[`ISQ_FLAG_I];
               flagRestore = 1'b1;
            end
            `ISQ_TAG_ACC:   n.acc = memRdData;
            `ISQ_TAG_IDX:   n.idx = memRdData;
            `ISQ_TAG_PCH:   n.pc[13:8] = memRdData[5:0];
            `ISQ_TAG_PCL:   n.pc[7:0] = memRdData;
            default: begin
            end
         endcase
      end

      unique case (r.st)
         ISQ_ST_RUN: begin
            if (pcLoad) begin
               n.pc = pcValue;
            end
            if (accWr) begin
               n.acc = accWrData;
            end
            if (idxWr) begin
               n.idx = idxWrData;
            end
            n.step = 3'h0;
            if (cmdValid) begin
               n.defer = 1'b0;
               unique case (cmd)
                  ISQ_CMD_NONE: begin
                  end
                  ISQ_CMD_CALL: begin
                     n.kind   = ISQ_KIND_CALL;
                     n.target = callTarget;
                     n.count  = `ISQ_CALL_PUSH_N;
                     n.st     = ISQ_ST_PUSH;
                  end
                  ISQ_CMD_SOFT_TRAP: begin
                     // not held off by the mask
                     n.kind  = ISQ_KIND_IRQ;
                     n.vec   = `ISQ_VEC_SOFT;
                     n.count = `ISQ_IRQ_PUSH_N;
                     n.st    = ISQ_ST_PUSH;
                  end
                  ISQ_CMD_TRAP_RETURN: begin
                     n.kind  = ISQ_KIND_RTI;
                     n.count = `ISQ_RTI_PULL_N;
                     n.st    = ISQ_ST_FETCH;
                  end
                  ISQ_CMD_SUB_RETURN: begin
                     n.kind  = ISQ_KIND_RTS;
                     n.count = `ISQ_RTS_PULL_N;
                     n.st    = ISQ_ST_FETCH;
                  end
                  ISQ_CMD_SP_PRESET: n.spLow = `ISQ_SP_RST;
                  ISQ_CMD_UNMASK: begin
                     n.iMask = 1'b0;
                     n.defer = 1'b1;
                  end
                  ISQ_CMD_MASK:      n.iMask = 1'b1;
               endcase
            end else if (instrDone) begin
               if (r.defer) begin
                  n.defer = 1'b0;
               end else if (!r.iMask && anyPend) begin
                  n.kind       = ISQ_KIND_IRQ;
                  n.vec        = pickVec;
                  n.count      = `ISQ_IRQ_PUSH_N;
                  n.st         = ISQ_ST_PUSH;
                  n.clrPrimary = lnk.pendPrimary;
               end
            end
         end
         ISQ_ST_PUSH: begin
            n.memWe     = 1'b1;
            n.memAddr   = spAddr;
            n.memWrData = push_byte(r, flagRegister);
            n.spLow     = r.spLow - 6'h01;
            n.step      = r.step + 3'h1;
            if (r.step == r.count - 3'h1) begin
               n.step = 3'h0;
               if (r.kind == ISQ_KIND_CALL) begin
                  n.pc = r.target;
                  n.st = ISQ_ST_RUN;
               end else begin
                  // mask goes up only once the frame is stacked
                  n.iMask = 1'b1;
                  n.count = `ISQ_VEC_READ_N;
                  n.st    = ISQ_ST_FETCH;
               end
            end
         end
         ISQ_ST_FETCH: begin
            n.memRe = 1'b1;
            n.rdV1  = 1'b1;
            n.step  = r.step + 3'h1;
            if (r.kind == ISQ_KIND_IRQ) begin
               n.memAddr = r.vec + {11'h000, r.step};
               n.rdTag1  = `ISQ_TAG_PCH + r.step;
            end else begin
               n.spLow   = r.spLow + 6'h01;
               n.memAddr = spAddrUp;
               n.rdTag1  = (r.kind == ISQ_KIND_RTS) ?
                           `ISQ_TAG_PCH + r.step : r.step;
            end
            if (r.step == r.count - 3'h1) begin
               n.st = ISQ_ST_DRAIN;
            end
         end
         ISQ_ST_DRAIN: begin
            if (!r.rdV1) begin
               n.st = ISQ_ST_RUN;
            end
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // after reset the sequencer starts by fetching the reset vector
   always_ff @(posedge mclk or posedge rstAny) begin
      if (rstAny) begin
         r           <= '0;
         r.st        <= ISQ_ST_FETCH;
         r.kind      <= ISQ_KIND_IRQ;
         r.count     <= `ISQ_VEC_READ_N;
         r.vec       <= `ISQ_VEC_RESET;
         r.spLow     <= `ISQ_SP_RST;
         r.iMask     <= 1'b1;
      end else begin
         r <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   assign busy              = (r.st != ISQ_ST_RUN);
   assign memAddr           = r.memAddr;
   assign memWrData         = r.memWrData;
   assign memWe             = r.memWe;
   assign memRe             = r.memRe;
   assign pc                = r.pc;
   assign sp                = spAddr;
   assign acc               = r.acc;
   assign idx               = r.idx;
   assign flagRegister      = {`ISQ_CC_PAD, lnk.hnzc[3], r.iMask,
                               lnk.hnzc[2:0]};
   assign effAddr           = {6'h00, r.idx} + idxOffset;
   assign miscRdData        = lnk.miscRdData;
   assign pinPrimaryLevel   = lnk.pinLevel[0];
   assign pinSecondaryLevel = lnk.pinLevel[1];
   // the floor leaves room for 31 call frames or 12 interrupt frames
   assign stackAtLimit      = (spAddr < `ISQ_SP_FLOOR);

endmodule : isq_top

// [tb/interrupt_stack_sequencer_test.sv]
`timescale 1ns/10ps
module interrupt_stack_sequencer_test import isq_pkg::*;;
   logic mclk, sys_rst, standbyPinN, extIrqPrimaryN, extIrqSecondaryN;
   logic timerEvent, secondTimerEvent, serialEvent, instrDone, cmdValid;
   logic pcLoad, accWr, idxWr, aluBit, miscWr, busy, memWe, memRe;
   logic pinPrimaryLevel, pinSecondaryLevel, stackAtLimit;
   logic [13:0] callTarget, pcValue, idxOffset, memAddr, pc, sp, effAddr, P;
   logic [7:0] accWrData, idxWrData, aluA, aluB, aluResult, miscWrData;
   logic [7:0] memRdData, memWrData, acc, idx, flagRegister, miscRdData;
   logic [7:0] A, X, cc, a, b;
   logic [8:0] s, d;
   isq_cmd_t cmd;
   isq_fop_t flagOp;
   int miscompares, compares;
   logic [21:0] expQ[$];
   isq_top i_isq_top (.*);
   isq_mem_model i_isq_mem_model (.*);
   ////////////////////////////////////////
   task chk(input string n, input logic [21:0] g, e);
      compares++;
      if (g !== e) begin
         miscompares++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task end_sim;
      if (miscompares == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_sim
   task tick(input int n);
      repeat (n) @(negedge mclk);
   endtask : tick
   task idle;
      for (int i = 0; busy !== 1'b0; i++) begin
         if (i > 60) begin
            miscompares++;
            end_sim;
         end
         tick(1);
      end
   endtask : idle
   task go(input isq_cmd_t c);
      cmdValid = 1;
      cmd = c;
      tick(1);
      cmdValid = 0;
      tick(1);
      idle;
   endtask : go
   task push(input logic [13:0] ad, input logic [7:0] dt);
      expQ.push_back({ad, dt});
   endtask : push
   task frame;
      push(14'h00ff, P[7:0]);
      push(14'h00fe, {2'h0, P[13:8]});
      push(14'h00fd, X);
      push(14'h00fc, A);
      push(14'h00fb, cc);
   endtask : frame
   task serve(input logic [13:0] v);
      frame;
      instrDone = 1;
      tick(1);
      instrDone = 0;
      tick(1);
      idle;
      chk("vector", pc, v);
   endtask : serve
   task fop(input isq_fop_t o, input logic [7:0] x, y, r,
            input logic t, input logic [3:0] m, e);
      flagOp = o;
      aluA = x;
      aluB = y;
      aluResult = r;
      aluBit = t;
      tick(1);
      flagOp = ISQ_FOP_NONE;
      chk("flags", {flagRegister[4], flagRegister[2:0]} & m, e & m);
   endtask : fop
   task mwr(input logic [7:0] v);
      miscWr = 1;
      miscWrData = v;
      tick(1);
      miscWr = 0;
      tick(1);
   endtask : mwr
   task rst(input logic sb);
      sys_rst = !sb;
      standbyPinN = !sb;
      tick(3);
      sys_rst = 0;
      standbyPinN = 1;
      tick(1);
      idle;
      chk("pc", pc, 14'h0100);
      chk("sp", sp, 14'h00ff);
      chk("misc", miscRdData, 8'h40);
   endtask : rst
   initial begin
      mclk = 0;
      forever #4 mclk = ~mclk;
   end
   // every stack write must match the oldest expected byte
   always @(negedge mclk)
      if (memWe === 1'b1) begin
         if (expQ.size() == 0)
            chk("push", {memAddr, memWrData}, '1);
         else
            chk("push", {memAddr, memWrData}, expQ.pop_front());
      end
   initial begin
      {sys_rst, standbyPinN, extIrqPrimaryN, extIrqSecondaryN} = 4'hf;
      {timerEvent, secondTimerEvent, serialEvent, instrDone, cmdValid} = 5'h0;
      {pcLoad, accWr, idxWr, aluBit, miscWr} = 5'h0;
      {callTarget, pcValue, idxOffset, accWrData, idxWrData} = 58'h0;
      {aluA, aluB, aluResult, miscWrData} = 32'h0;
      cmd = ISQ_CMD_NONE;
      flagOp = ISQ_FOP_NONE;
      miscompares = 0;
      compares = 0;
      void'($urandom(32'h7b3f));
      rst(1'b0);
      repeat (4) begin
         a = 8'($urandom);
         b = 8'($urandom);
         s = a + b;
         fop(ISQ_FOP_ADD, a, b, s[7:0], 1'b0, 4'hf, {(a & 8'h0f)
             + (b & 8'h0f) > 8'h0f, s[7], s[7:0] == 8'h00, s[8]});
         d = a + b + s[8];
         fop(ISQ_FOP_ADC, a, b, d[7:0], 1'b0, 4'hf, {(a & 8'h0f)
             + (b & 8'h0f) + s[8] > 8'h0f, d[7], d[7:0] == 8'h00, d[8]});
         s = a - b;
         fop(ISQ_FOP_SUB, a, b, s[7:0], 1'b0, 4'h7,
             {1'b0, s[7], s[7:0] == 8'h00, s[8]});
         fop(ISQ_FOP_ROTATE, a, b, b, a[0], 4'h7,
             {1'b0, b[7], b == 8'h00, a[0]});
         fop(ISQ_FOP_BITTEST, a, b, a, b[0], 4'h1, {3'h0, b[0]});
      end
      fop(ISQ_FOP_LOGIC, 8'h00, 8'h00, 8'h00, 1'b0, 4'h6, 4'h2);
      fop(ISQ_FOP_ADD, 8'h08, 8'h08, 8'h10, 1'b0, 4'hf, 4'h8);
      cc = 8'hf8;
      P = 14'($urandom);
      A = 8'($urandom);
      X = 8'($urandom);
      idxOffset = 14'($urandom);
      pcValue = P;
      accWrData = A;
      idxWrData = X;
      {pcLoad, accWr, idxWr} = 3'h7;
      tick(1);
      {pcLoad, accWr, idxWr} = 3'h0;
      chk("ea", effAddr, 14'({6'h0, X} + idxOffset));
      chk("pc", pc, P);
      for (int k = 0; k < 2; k++) begin
         callTarget = k ? P : ~P;
         push(14'h00ff, P[7:0]);
         push(14'h00fe, {2'h0, P[13:8]});
         go(ISQ_CMD_CALL);
         chk("call", {sp[7:0], pc}, {8'hfd, callTarget});
         go(k ? ISQ_CMD_SP_PRESET : ISQ_CMD_SUB_RETURN);
         chk("sp", sp, 14'h00ff);
      end
      for (int j = 0; j < 62; j += 2) begin
         push(14'(255 - j), P[7:0]);
         push(14'(254 - j), {2'h0, P[13:8]});
         go(ISQ_CMD_CALL);
      end
      chk("lim", {sp, stackAtLimit}, {14'h00c1, 1'b0});
      go(ISQ_CMD_SP_PRESET);
      frame;
      go(ISQ_CMD_SOFT_TRAP);
      chk("pc", pc, 14'h0200);
      go(ISQ_CMD_TRAP_RETURN);
      chk("ret", {pc, acc}, {P, A});
      chk("cc", flagRegister, cc);
      mwr(8'h80);
      chk("misc", miscRdData, 8'h00);
      {timerEvent, serialEvent, extIrqPrimaryN, extIrqSecondaryN} = 4'hc;
      tick(2);
      chk("misc", miscRdData, 8'h80);
      {extIrqPrimaryN, extIrqSecondaryN} = 2'h3;
      go(ISQ_CMD_UNMASK);
      cc = 8'hf0;
      instrDone = 1;
      tick(1);
      instrDone = 0;
      tick(2);
      chk("busy", busy, 1'b0);
      serve(14'h0300);
      chk("misc", miscRdData, 8'h80);
      go(ISQ_CMD_TRAP_RETURN);
      serve(14'h0400);
      timerEvent = 0;
      mwr(8'h00);
      chk("misc", miscRdData, 8'h00);
      go(ISQ_CMD_TRAP_RETURN);
      serve(14'h0500);
      serialEvent = 0;
      secondTimerEvent = 1;
      go(ISQ_CMD_TRAP_RETURN);
      serve(14'h0500);
      secondTimerEvent = 0;
      mwr(8'h40);
      extIrqSecondaryN = 0;
      go(ISQ_CMD_TRAP_RETURN);
      instrDone = 1;
      tick(1);
      instrDone = 0;
      tick(2);
      chk("busy", busy, 1'b0);
      chk("misc", {miscRdData, pinSecondaryLevel}, 9'h180);
      go(ISQ_CMD_MASK);
      chk("mask", flagRegister, 8'hf8);
      extIrqSecondaryN = 1;
      rst(1'b1);
      chk("queue", 22'(expQ.size()), 22'h0);
      end_sim;
   end
endmodule : interrupt_stack_sequencer_test

// [tb/isq_mem_model.sv]
`timescale 1ns/10ps
module isq_mem_model (
   input wire logic        mclk,
   input wire logic [13:0] memAddr,
   input wire logic [7:0]  memWrData,
   input wire logic        memWe,
   input wire logic        memRe,
   output logic [7:0]      memRdData
);
   logic [7:0] mem [16384];
   initial begin
      memRdData = 8'h00;
      foreach (mem[i]) mem[i] = 8'h00;
      // handlers at 0100..0500, high byte at the even location
      for (int k = 0; k < 5; k++) mem[14'h1ffe - 2 * k] = 8'(k + 1);
   end
   // between reads the bus toggles so a stale byte is never trusted
   always @(posedge mclk) begin
      if (memWe) mem[memAddr] <= memWrData;
      memRdData <= memRe ? mem[memAddr] : ~memRdData;
   end
endmodule : isq_mem_model

// [tb/isq_top_assertions.sv]
`timescale 1ns/10ps
module isq_top_assertions import isq_pkg::*; (
   input wire logic        mclk,
   input wire logic        sys_rst,
   input wire logic        standbyPinN,
   input wire logic        extIrqPrimaryN,
   input wire logic        extIrqSecondaryN,
   input wire logic        memWe,
   input wire logic        memRe,
   input wire logic [13:0] memAddr,
   input wire logic [13:0] sp,
   input wire logic [7:0]  flagRegister,
   input wire logic [7:0]  miscRdData,
   input wire logic        miscWr,
   input wire logic        pinPrimaryLevel,
   input wire logic        stackAtLimit
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst || !standbyPinN);
   chk_sp_top: assert property (sp[13:6] == 8'h03)
      else $error("sp top bits moved");
   chk_push_area: assert property (memWe |-> !memRe && memAddr[13:6] == 8'h03)
      else $error("push off stack page");
   chk_raw_pin: assert property (pinPrimaryLevel == extIrqPrimaryN)
      else $error("pin level not raw");
   chk_edge_req: assert property ($fell(extIrqSecondaryN) |=> miscRdData[7])
      else $error("edge not latched");
   chk_no_sw_set: assert property (!miscRdData[7] && miscWr
      && extIrqSecondaryN && $past(extIrqSecondaryN) |=> !miscRdData[7])
      else $error("request set by write");
   chk_reset_val: assert property ($fell(sys_rst) |-> miscRdData == 8'h40
      && sp == 14'h00ff && flagRegister[3])
      else $error("bad reset values");
   chk_mask_set: assert property (memWe [*5] |=> memRe ##2 flagRegister[3])
      else $error("mask not set on entry");
   chk_vec_pair: assert property (memRe && memAddr[13:4] == 10'h1ff
      && !memAddr[0] |=> memRe && memAddr == $past(memAddr) + 14'h1)
      else $error("vector pair order");
   chk_stack_lim: assert property (stackAtLimit == (sp == 14'h00c0))
      else $error("stack limit flag");
   cover property (memWe [*5]);
   cover property (memWe [*2] ##1 !memWe);
   cover property ($rose(miscRdData[7]));
endmodule : isq_top_assertions
bind isq_top isq_top_assertions i_chk (.*);
